// *** cm_pkg.sv ***
`default_nettype none
package cm_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] ADDR_OFS = 8'h00;
	localparam logic [7:0] DATA_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] CTRL_OFS = 8'h0C;
	// memory address layout (14 bits, octal 00000-37777)
	localparam int ADDR_W = 14;
	localparam int STACK_BIT = 13;
	localparam int UPPER_BIT = 12;
	localparam int X_HI_POS = 9;
	localparam int X_LO_POS = 6;
	localparam int Y_HI_POS = 3;
	localparam int Y_LO_POS = 0;
	// word and card geometry
	localparam int WORD_W = 17;
	localparam int MODULES = 4;
	localparam int CARDS = 4;
	localparam int CARD_GATES = 32;
	// status and control field positions
	localparam int STAT_PG_POS = 0;
	localparam int STAT_SEL_POS = 1;
	localparam int CTRL_EN_POS = 0;
	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
	localparam logic [WORD_W-1:0] DATA_RST = 17'h0_0000;
	localparam logic CTRL_EN_RST = 1'b0;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SENSE_PULSE_NS = 200;
	localparam int SENSE_PULSE_CYCLES = SENSE_PULSE_NS / CLK_PERIOD_NS;
	typedef logic [WORD_W-1:0] cm_word_type;
endpackage
`default_nettype wire

// *** cm_gate_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface cm_gate_if;
	logic [2:0] upper_octal_digit;
	logic [2:0] lower_octal_digit;
	logic drv_rd_en;
	logic drv_wr_en;
	logic sw_rd_en;
	logic sw_wr_en;
	logic swap;
	logic [7:0] drv_a;
	logic [7:0] drv_b;
	logic [7:0] sw_a;
	logic [7:0] sw_b;
	modport ctl(output upper_octal_digit, lower_octal_digit, drv_rd_en,
		drv_wr_en, sw_rd_en, sw_wr_en, swap,
		input drv_a, drv_b, sw_a, sw_b);
	modport dec(input upper_octal_digit, lower_octal_digit, drv_rd_en,
		drv_wr_en, sw_rd_en, sw_wr_en, swap,
		output drv_a, drv_b, sw_a, sw_b);
endinterface
`default_nettype wire

// *** cm_gate_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module cm_gate_decode (
	cm_gate_if.dec g
);
	// gate b reads and gate a writes, unless swap turns the pair round
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_digit
			wire hit_hi = g.upper_octal_digit == 3'(i);
			wire hit_lo = g.lower_octal_digit == 3'(i);
			assign g.drv_b[i] = hit_hi & (g.swap ? g.drv_wr_en : g.drv_rd_en);
			assign g.drv_a[i] = hit_hi & (g.swap ? g.drv_rd_en : g.drv_wr_en);
			assign g.sw_b[i] = hit_lo & (g.swap ? g.sw_wr_en : g.sw_rd_en);
			assign g.sw_a[i] = hit_lo & (g.swap ? g.sw_rd_en : g.sw_wr_en);
		end
	endgenerate
endmodule
`default_nettype wire

// *** cm_inhibit_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
module cm_inhibit_bank (
	input wire logic inhibit_window_pulse,
	input wire logic module_sel,
	input wire cm_pkg::cm_word_type data,
	output logic [cm_pkg::WORD_W-1:0] drive
);
	wire gated_pulse = inhibit_window_pulse & module_sel;
	genvar b;
	generate
		for (b = 0; b < cm_pkg::WORD_W; b++) begin : g_bit
			// a zero bit holds its core out of the one state
			assign drive[b] = gated_pulse & ~data[b];
		end
	endgenerate
endmodule
`default_nettype wire

// *** cm_select_inhibit.sv ***
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module cm_select_inhibit (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic power_good_gate,
	input wire logic read_drive_pulse,
	input wire logic inhibit_window_pulse,
	input wire logic write_switch_pulse,
	input wire logic sense_load_strobe,
	input wire logic [67:0] sense_in,
	output logic [31:0] y_select_card_stack0,
	output logic [31:0] x_select_card_stack0,
	output logic [31:0] y_select_card_stack1,
	output logic [31:0] x_select_card_stack1,
	output logic module_sel_s0_low,
	output logic module_sel_s0_high,
	output logic module_sel_s1_low,
	output logic module_sel_s1_high,
	output logic [67:0] inhibit_drive
);
	localparam int SENSE_ALL = cm_pkg::MODULES * cm_pkg::WORD_W;

	logic [cm_pkg::ADDR_W-1:0] mem_addr;
	cm_pkg::cm_word_type mem_data;
	logic gate_enable;
	logic pg_s1, pg_s2, pg_s3, pg_ok;
	logic [SENSE_ALL-1:0] sn_s1, sn_s2, sn_s3, sense_state;
	logic [cm_pkg::CARD_GATES-1:0] card_gate [cm_pkg::CARDS];
	logic [3:0] mod_sel;
	logic [SENSE_ALL-1:0] inh_q;

	// ---------------- wishbone slave ----------------
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;
	wire hit_addr = wb_adr_i == cm_pkg::ADDR_OFS;
	wire hit_data = wb_adr_i == cm_pkg::DATA_OFS;
	wire hit_stat = wb_adr_i == cm_pkg::STAT_OFS;
	wire hit_ctrl = wb_adr_i == cm_pkg::CTRL_OFS;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (sel[k]) begin
				r[k*8 +: 8] = wd[k*8 +: 8];
			end
		end
		return r;
	endfunction

	wire [31:0] addr_word = {18'h0_0000, mem_addr};
	wire [31:0] data_word = {15'h0000, mem_data};
	wire [31:0] stat_word = {27'h000_0000, mod_sel, pg_ok};
	wire [31:0] ctrl_word = {31'h0000_0000, gate_enable};
	wire [31:0] addr_merged = merge(addr_word, wb_dat_i, wb_sel_i);
	wire [31:0] data_merged = merge(data_word, wb_dat_i, wb_sel_i);
	wire [31:0] ctrl_merged = merge(ctrl_word, wb_dat_i, wb_sel_i);
	// unmapped offsets read zero and still get an ack
	wire [31:0] next_rdata = hit_addr ? addr_word :
		hit_data ? data_word :
		hit_stat ? stat_word :
		hit_ctrl ? ctrl_word : 32'h0000_0000;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mem_addr <= cm_pkg::ADDR_RST;
			gate_enable <= cm_pkg::CTRL_EN_RST;
		end else if (ce && wb_wr) begin
			if (hit_addr) begin
				mem_addr <= addr_merged[cm_pkg::ADDR_W-1:0];
			end
			if (hit_ctrl) begin
				gate_enable <= ctrl_merged[cm_pkg::CTRL_EN_POS];
			end
		end
	end

	// ---------------- input synchronisers ----------------
	// power good and sense lines come from analog cards, not this clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pg_s1 <= 1'b0;
			pg_s2 <= 1'b0;
			pg_s3 <= 1'b0;
			sn_s1 <= '0;
			sn_s2 <= '0;
			sn_s3 <= '0;
		end else if (ce) begin
			pg_s1 <= power_good_gate;
			pg_s2 <= pg_s1;
			pg_s3 <= pg_s2;
			sn_s1 <= sense_in;
			sn_s2 <= sn_s1;
			sn_s3 <= sn_s2;
		end
	end

	// a change is taken once the second and third stages agree
	wire next_pg = (pg_s2 & pg_s3) | (pg_ok & (pg_s2 | pg_s3));
	wire [SENSE_ALL-1:0] next_sense = (sn_s2 & sn_s3) |
		(sense_state & (sn_s2 | sn_s3));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pg_ok <= 1'b0;
			sense_state <= '0;
		end else if (ce) begin
			// no hold-off is added on loss: gates follow pg_ok and gate_enable
			pg_ok <= next_pg;
			sense_state <= next_sense;
		end
	end

	// ---------------- address decode ----------------
	wire stack1 = mem_addr[cm_pkg::STACK_BIT];
	wire upper = mem_addr[cm_pkg::UPPER_BIT];
	wire [3:0] next_mod_sel = { stack1 & upper, stack1 & ~upper,
		~stack1 & upper, ~stack1 & ~upper};
	wire [1:0] mod_idx = {stack1, upper};
	wire [2:0] x_hi = mem_addr[cm_pkg::X_HI_POS +: 3];
	wire [2:0] x_lo = mem_addr[cm_pkg::X_LO_POS +: 3];
	wire [2:0] y_hi = mem_addr[cm_pkg::Y_HI_POS +: 3];
	wire [2:0] y_lo = mem_addr[cm_pkg::Y_LO_POS +: 3];
	wire drive_ok = pg_ok & gate_enable;

	genvar c;
	generate
		for (c = 0; c < cm_pkg::CARDS; c++) begin : g_card
			// cards 0/1 are Y/X of stack 0, cards 2/3 Y/X of stack 1
			localparam bit IS_X = (c % 2) == 1;
			localparam bit STK = c >= 2;
			cm_gate_if gi();
			wire active = drive_ok & (stack1 == STK);
			assign gi.upper_octal_digit = IS_X ? x_hi : y_hi;
			assign gi.lower_octal_digit = IS_X ? x_lo : y_lo;
			assign gi.drv_rd_en = active & read_drive_pulse;
			// inhibit pulse re-selects the same driver for writing
			assign gi.drv_wr_en = active & inhibit_window_pulse;
			assign gi.sw_rd_en = active & read_drive_pulse;
			assign gi.sw_wr_en = active & write_switch_pulse;
			assign gi.swap = IS_X & upper;
			cm_gate_decode u_dec (
				.g(gi)
			);
			wire [cm_pkg::CARD_GATES-1:0] next_gate = {gi.sw_a, gi.sw_b,
				gi.drv_a, gi.drv_b};
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					card_gate[c] <= '0;
				end else if (ce) begin
					card_gate[c] <= next_gate;
				end
			end
		end
	endgenerate

	assign y_select_card_stack0 = card_gate[0];
	assign x_select_card_stack0 = card_gate[1];
	assign y_select_card_stack1 = card_gate[2];
	assign x_select_card_stack1 = card_gate[3];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mod_sel <= 4'h0;
		end else if (ce) begin
			mod_sel <= next_mod_sel;
		end
	end
	assign module_sel_s0_low = mod_sel[0];
	assign module_sel_s0_high = mod_sel[1];
	assign module_sel_s1_low = mod_sel[2];
	assign module_sel_s1_high = mod_sel[3];

	// ---------------- data register ----------------
	// strobe wins over a software write in the same cycle
	wire [cm_pkg::WORD_W-1:0] sensed = sense_state[mod_idx*cm_pkg::WORD_W +:
		cm_pkg::WORD_W];
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mem_data <= cm_pkg::DATA_RST;
		end else if (ce) begin
			if (sense_load_strobe) begin
				mem_data <= sensed;
			end else if (wb_wr && hit_data) begin
				mem_data <= data_merged[cm_pkg::WORD_W-1:0];
			end
		end
	end

	// ---------------- inhibit drivers ----------------
	generate
		for (c = 0; c < cm_pkg::MODULES; c++) begin : g_inh
			logic [cm_pkg::WORD_W-1:0] drv;
			cm_inhibit_bank u_inh (
				.inhibit_window_pulse(inhibit_window_pulse),
				.module_sel(next_mod_sel[c]),
				.data(mem_data),
				.drive(drv)
			);
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					inh_q[c*cm_pkg::WORD_W +: cm_pkg::WORD_W] <= '0;
				end else if (ce) begin
					inh_q[c*cm_pkg::WORD_W +: cm_pkg::WORD_W] <= drv;
				end
			end
		end
	endgenerate
	assign inhibit_drive = inh_q;

	// ---------------- assertions ----------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence pg_settle;
		ce && power_good_gate ##1 ce && power_good_gate ##1
			ce && power_good_gate ##1 ce && power_good_gate;
	endsequence

	sequence pg_drop;
		ce && !power_good_gate ##1 ce && !power_good_gate ##1
			ce && !power_good_gate ##1 ce && !power_good_gate;
	endsequence

	// last cycle of the pulse, then the first quiet one
	sequence inh_end;
		ce && inhibit_window_pulse ##1 ce && !inhibit_window_pulse;
	endsequence

	AST_NO_DRIVE_WITHOUT_PG: assert property (ce && !pg_ok |=>
		(y_select_card_stack0 | x_select_card_stack0 |
		y_select_card_stack1 | x_select_card_stack1) == 32'h0000_0000)
		else $error("driver gate active without power good");

	AST_PG_RISE: assert property (pg_settle |=> pg_ok)
		else $error("power good not taken after agreement");

	AST_Y_READ: assert property (ce && drive_ok && read_drive_pulse &&
		!inhibit_window_pulse && !stack1 |=>
		y_select_card_stack0[7:0] == 8'h01 << $past(y_hi) &&
		y_select_card_stack0[15:8] == 8'h00)
		else $error("Y read gate does not follow digit");

	AST_X_SWAP: assert property (ce && drive_ok && read_drive_pulse &&
		!inhibit_window_pulse && !stack1 && upper |=>
		x_select_card_stack0[15:8] == 8'h01 << $past(x_hi) &&
		x_select_card_stack0[7:0] == 8'h00)
		else $error("X upper read uses wrong gate");

	AST_X_STACK: assert property (ce && !stack1 |=>
		x_select_card_stack1 == 32'h0000_0000)
		else $error("stack 1 X card active for low address");

	AST_SENSE_LOAD: assert property (ce && sense_load_strobe |=>
		mem_data == $past(sensed))
		else $error("data register not loaded from sense");

	AST_INHIBIT: assert property (ce && inhibit_window_pulse &&
		!upper && !stack1 |=>
		inhibit_drive[16:0] == ~$past(mem_data) &&
		inhibit_drive[67:17] == 51'h0)
		else $error("inhibit drive mismatch");

	AST_INHIBIT_OFF: assert property (ce && !inhibit_window_pulse |=>
		inhibit_drive == 68'h0)
		else $error("inhibit drive after pulse end");

	AST_MOD_SEL: assert property (ce |=> $onehot(mod_sel) &&
		mod_sel[{$past(stack1), $past(upper)}])
		else $error("module select not one-hot");

	AST_WRITE_SWITCH: assert property (ce && drive_ok &&
		write_switch_pulse && !stack1 |=>
		y_select_card_stack0[31:24] == 8'h01 << $past(y_lo))
		else $error("write switch gate missing");

	AST_PG_FALL: assert property (pg_drop |=> !pg_ok)
		else $error("power good loss not taken");

	AST_INHIBIT_END: assert property (inh_end |=>
		inhibit_drive == 68'h0)
		else $error("inhibit drive outlives its pulse");

	AST_STACK0_QUIET: assert property (ce && stack1 |=>
		(y_select_card_stack0 | x_select_card_stack0) == 32'h0000_0000)
		else $error("stack 0 cards active for high address");

	AST_Y1_READ: assert property (ce && drive_ok && read_drive_pulse &&
		!inhibit_window_pulse && stack1 |=>
		y_select_card_stack1[7:0] == 8'h01 << $past(y_hi) &&
		y_select_card_stack1[23:16] == 8'h01 << $past(y_lo))
		else $error("stack 1 Y read gate does not follow digit");

	AST_X_LOWER: assert property (ce && drive_ok && read_drive_pulse &&
		!inhibit_window_pulse && !stack1 && !upper |=>
		x_select_card_stack0[7:0] == 8'h01 << $past(x_hi) &&
		x_select_card_stack0[15:8] == 8'h00)
		else $error("X lower read uses wrong gate");

	AST_X_UPPER_WRITE: assert property (ce && drive_ok &&
		write_switch_pulse && !read_drive_pulse && !stack1 && upper |=>
		x_select_card_stack0[23:16] == 8'h01 << $past(x_lo) &&
		x_select_card_stack0[31:24] == 8'h00)
		else $error("X upper write switch uses wrong gate");

	AST_INHIBIT_S1_HIGH: assert property (ce && inhibit_window_pulse &&
		stack1 && upper |=>
		inhibit_drive[67:51] == ~$past(mem_data) &&
		inhibit_drive[50:0] == 51'h0)
		else $error("inhibit drive outside stack 1 upper module");

	AST_GATE_IDLE: assert property (ce && !read_drive_pulse &&
		!inhibit_window_pulse && !write_switch_pulse |=>
		(y_select_card_stack0 | x_select_card_stack0 |
		y_select_card_stack1 | x_select_card_stack1) == 32'h0000_0000)
		else $error("gate active with no timing pulse");
endmodule
`default_nettype wire

// *** cm_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cm_core_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic read_drive_pulse,
	input wire logic [16:0] word,
	input wire logic [1:0] mod,
	output logic [67:0] sense_in
);
	logic [5:0] cnt;
	logic rd_q;
	// idle sense lines sit at zero, just like a quiet amplifier
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 6'h00;
			rd_q <= 1'h0;
			sense_in <= 68'h0;
		end else begin
			rd_q <= read_drive_pulse;
			if (read_drive_pulse && !rd_q)
				cnt <= 6'h01;
			else if (cnt != 6'h00 && cnt < 6'h16)
				cnt <= cnt + 6'h01;
			else
				cnt <= 6'h00;
			// only stored ones give a pulse, 20 cycles long
			if (cnt >= 6'h02 && cnt < 6'h16)
				sense_in <= {51'h0, word} << (mod * 17);
			else
				sense_in <= 68'h0;
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic power_good_gate = 1'h0;
	logic [2:0] pulses = 3'h0;
	logic sense_load_strobe = 1'h0;
	logic [16:0] word = 17'h0_0000;
	logic [1:0] mod = 2'h0;
	logic [13:0] a;
	logic [31:0] q;
	wire logic [31:0] wb_dat_o, yc0, xc0, yc1, xc1;
	wire logic wb_ack_o;
	wire logic [3:0] msel;
	wire logic [67:0] sense_in, inhibit_drive;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc_cnt = 0;
	cm_select_inhibit dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.power_good_gate(power_good_gate), .read_drive_pulse(pulses[0]),
		.inhibit_window_pulse(pulses[1]), .write_switch_pulse(pulses[2]),
		.sense_load_strobe(sense_load_strobe), .sense_in(sense_in),
		.y_select_card_stack0(yc0), .x_select_card_stack0(xc0),
		.y_select_card_stack1(yc1), .x_select_card_stack1(xc1),
		.module_sel_s0_low(msel[0]), .module_sel_s0_high(msel[1]),
		.module_sel_s1_low(msel[2]), .module_sel_s1_high(msel[3]),
		.inhibit_drive(inhibit_drive));
	cm_core_model core (.sys_clk(sys_clk), .rst(rst),
		.read_drive_pulse(pulses[0]), .word(word), .mod(mod),
		.sense_in(sense_in));
	always #5 sys_clk = ~sys_clk;
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			$display("CHECK FAILED %0t timeout", $time);
			give_verdict();
		end
	end
	task chk_w(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
		end
	endtask
	task chk_i(input logic [67:0] got, input logic [67:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
		end
	endtask
	// entered just after an edge; holds the request until ack is seen
	// only the global timeout ends a wait for ack
	task wb(input logic [7:0] ad, input logic we, input logic [31:0] d);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
		@(posedge sys_clk);
		// ack stands for one cycle only
		chk_w({31'h0, wb_ack_o}, 32'h0, "ack one cycle");
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] e, input string m);
		wb(ad, 1'h0, 32'h0000_0000);
		chk_w(q, e, m);
	endtask
	// phase 0 read, 1 inhibit, 2 write switch; outputs lag one edge
	task pulse(input int ph);
		pulses <= 3'h1 << ph;
		repeat (2) @(posedge sys_clk);
	endtask
	function automatic logic [31:0] gexp(input logic [2:0] hi,
		input logic [2:0] lo, input int ph, input logic swp);
		logic s;
		logic [31:0] r;
		s = (ph == 0) ? swp : ~swp;
		r = 32'h0000_0000;
		if (ph != 2)
			r[(s ? 8 : 0) + hi] = 1'h1;
		if (ph != 1)
			r[(s ? 24 : 16) + lo] = 1'h1;
		return r;
	endfunction
	task cards(input logic s, input logic [31:0] y, input logic [31:0] x);
		chk_w(yc0, s ? 32'h0 : y, "y card 0");
		chk_w(yc1, s ? y : 32'h0, "y card 1");
		chk_w(xc0, s ? 32'h0 : x, "x card 0");
		chk_w(xc1, s ? x : 32'h0, "x card 1");
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		rd(8'h0C, 32'h0, "ctrl reset");
		rd(8'h00, 32'h0, "addr reset");
		wb(8'h10, 1'h1, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0, "unmapped");
		$display("test reset done");
		// power still low: enabled gates must stay dark
		wb(8'h0C, 1'h1, 32'h1);
		wb(8'h00, 1'h1, 32'h0000_0A5B);
		for (int ph = 0; ph < 3; ph++) begin
			pulse(ph);
			cards(1'h0, 32'h0, 32'h0);
			pulses <= 3'h0;
			@(posedge sys_clk);
		end
		rd(8'h08, 32'h2, "status pg low");
		$display("test power block done");
		power_good_gate <= 1'h1;
		repeat (8) @(posedge sys_clk);
		for (int m = 0; m < 4; m++) begin
			for (int d = 0; d < 8; d++) begin
				a = {m[1:0], d[2:0], 3'(7 - d), 3'(d + 3), 3'(d ^ 5)};
				wb(8'h00, 1'h1, {18'h0, a});
				rd(8'h08, 32'h1 | (32'h2 << m), "status");
				chk_w({28'h0, msel}, 32'h1 << m, "msel");
				for (int ph = 0; ph < 3; ph++) begin
					pulse(ph);
					cards(m[1], gexp(a[5:3], a[2:0], ph, 1'h0),
						gexp(a[11:9], a[8:6], ph, m[0]));
					pulses <= 3'h0;
					@(posedge sys_clk);
				end
			end
		end
		$display("test gate decode done");
		for (int m = 0; m < 4; m++) begin
			word <= 17'h1_5A3C ^ (17'h0_1111 << m);
			mod <= m[1:0];
			wb(8'h00, 1'h1, 32'(m) << 12);
			wb(8'h04, 1'h1, 32'h0);
			pulses <= 3'h1;
			repeat (12) @(posedge sys_clk);
			sense_load_strobe <= 1'h1;
			@(posedge sys_clk);
			sense_load_strobe <= 1'h0;
			repeat (12) @(posedge sys_clk);
			pulses <= 3'h0;
			@(posedge sys_clk);
			rd(8'h04, {15'h0, word}, "data");
			pulse(1);
			chk_i(inhibit_drive, {51'h0, ~word} << (m * 17), "inh");
			pulses <= 3'h0;
			repeat (2) @(posedge sys_clk);
			chk_i(inhibit_drive, 68'h0, "inh off");
		end
		$display("test sense and inhibit done");
		// clock enable low freezes the gates even with a pulse present
		a = 14'h1A5B;
		wb(8'h00, 1'h1, {18'h0, a});
		ce <= 1'h0;
		pulses <= 3'h1;
		repeat (3) @(posedge sys_clk);
		cards(1'h0, 32'h0, 32'h0);
		ce <= 1'h1;
		repeat (2) @(posedge sys_clk);
		cards(a[13], gexp(a[5:3], a[2:0], 0, 1'h0),
			gexp(a[11:9], a[8:6], 0, a[12]));
		pulses <= 3'h0;
		@(posedge sys_clk);
		$display("test clock enable done");
		// timing generator is halted, no pulses, before power goes
		power_good_gate <= 1'h0;
		repeat (6) @(posedge sys_clk);
		rd(8'h08, 32'h4, "status pg lost");
		pulse(0);
		cards(1'h0, 32'h0, 32'h0);
		pulses <= 3'h0;
		@(posedge sys_clk);
		$display("test power loss done");
		give_verdict();
	end
endmodule
`default_nettype wire
